// ===== verilog/spt_top.sv
// Serial program transfer engine: 8-N-1 link, load and save sequencing
// Overview of operation
// - Link runs asynchronous framing at 19200 baud from the system clock.
// - Frames carry eight data bits, one stop bit, no parity.
// - Each program line ends with one linefeed character.
// - Each received line is fully processed before the next is accepted.
// - A question mark is sent each time the device awaits a line.
// - Save sends every stored line, then one empty line.
// - Load ends when the whole program arrived, then returns ready.
// - Load discards the held program before storing received lines.
// - Load mode 0 is text program, mode 1 is binary image.
// - Port number 1 selects the serial programming connector.
// - A transfer error aborts the operation with a system error.
`timescale 1ns/1ns
module spt_top #(
    parameter int unsigned MEM_DEPTH = 1024,
    parameter int unsigned CLK_FREQ_HZ = spt_pkg::CLK_HZ
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load_start,
    input wire logic save_start,
    input wire logic [7:0] port_num,
    input wire logic load_mode,
    input wire logic line_processed,
    input wire logic rx_pin,
    output logic tx_pin,
    output logic busy,
    output logic ready_pulse,
    output logic sys_error,
    output logic mem_cleared,
    output logic mode_binary,
    output logic line_valid,
    output logic [7:0] rx_data,
    output logic rx_data_valid
);
    import spt_pkg::*;

    localparam int AW = $clog2(MEM_DEPTH);

    // ****************************************
    // Bit timing and decode helpers
    // ****************************************
    // Whole and half bit lengths in clock cycles, rounded down
    localparam int unsigned BIT_N = CLK_FREQ_HZ / BAUD;
    // Start bit is checked at its middle
    localparam int unsigned HALF_N = BIT_N / 2;

    // True for the end-of-line character
    function automatic logic is_lf(input logic [7:0] ch);
        return (ch == CH_LF);
    endfunction

    // ****************************************
    // Program memory
    // ****************************************
    logic [7:0] mem [MEM_DEPTH];
    logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [7:0] mem_rd;
    assign mem_rd = mem[rd_ptr_q];

    // ****************************************
    // Receiver
    // ****************************************
    spt_rx_type rx_st_q;
    logic [15:0] rx_cnt_q;
    logic [2:0] rx_bit_q;
    logic [7:0] rx_sh_q;
    logic rx_done_q, rx_ferr_q;
    wire rx_tick = (rx_cnt_q == 16'(BIT_N - 1));
    wire rx_half = (rx_cnt_q == 16'(HALF_N - 1));

    always_ff @(posedge clk) begin
        rx_done_q <= 1'b0;
        rx_ferr_q <= 1'b0;
        if (!rstn) begin
            rx_st_q <= SPT_RX_IDLE;
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
        end else begin
            rx_cnt_q <= rx_cnt_q + 16'h0001;
            case (rx_st_q)
                SPT_RX_IDLE: begin
                    rx_cnt_q <= 16'h0000;
                    if (!rx_pin) rx_st_q <= SPT_RX_START;
                end
                SPT_RX_START: begin
                    if (rx_half) begin
                        rx_cnt_q <= 16'h0000;
                        rx_bit_q <= 3'h0;
                        rx_st_q <= rx_pin ? SPT_RX_IDLE : SPT_RX_DATA;
                    end
                end
                SPT_RX_DATA: begin
                    if (rx_tick) begin
                        rx_cnt_q <= 16'h0000;
                        rx_sh_q <= {rx_pin, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == 3'(DATA_BITS - 1)) rx_st_q <= SPT_RX_STOP;
                    end
                end
                SPT_RX_STOP: begin
                    if (rx_tick) begin
                        rx_st_q <= SPT_RX_IDLE;
                        if (rx_pin) rx_done_q <= 1'b1;
                        else rx_ferr_q <= 1'b1;
                    end
                end
                default: rx_st_q <= SPT_RX_IDLE;
            endcase
        end
    end

    // ****************************************
    // Transmitter
    // ****************************************
    logic [9:0] tx_sh_q;
    logic [3:0] tx_left_q;
    logic [15:0] tx_cnt_q;
    logic tx_go;
    logic [7:0] tx_byte;
    wire tx_idle = (tx_left_q == 4'h0);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_sh_q <= 10'h3FF;
            tx_left_q <= 4'h0;
            tx_cnt_q <= 16'h0000;
            tx_pin <= 1'b1;
        end else if (tx_go && tx_idle) begin
            tx_sh_q <= {1'b1, tx_byte, 1'b0};
            tx_left_q <= 4'hA;
            tx_cnt_q <= 16'h0000;
            tx_pin <= 1'b0;
        end else if (!tx_idle) begin
            tx_cnt_q <= tx_cnt_q + 16'h0001;
            if (tx_cnt_q == 16'(BIT_N - 1)) begin
                tx_cnt_q <= 16'h0000;
                tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                tx_left_q <= tx_left_q - 4'h1;
                tx_pin <= (tx_left_q == 4'h1) ? 1'b1 : tx_sh_q[1];
            end
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    spt_state_type st_q, st_d;
    logic empty_line_q, empty_line_d;
    wire port_ok = (port_num == PORT_SERIAL);
    wire save_end = (rd_ptr_q == wr_ptr_q);
    wire line_end = is_lf(rx_sh_q);
    // A linefeed straight after another one ends the program
    wire empty_end = line_end && empty_line_q;
    // Pointer at the last entry; that entry stays unused and a further byte is refused
    wire mem_full = (wr_ptr_q == AW'(MEM_DEPTH - 1));
    wire recv_byte = (st_q == SPT_RECV) && rx_done_q;
    wire load_taken = (st_q == SPT_IDLE) && load_start && port_ok;
    // Start refused for any port but the serial connector
    wire bad_start = (st_q == SPT_IDLE) && (load_start || save_start) && !port_ok;
    wire err_now = ((st_q == SPT_RECV) && rx_ferr_q) ||
        (recv_byte && mem_full && !empty_end);
    wire store_now = recv_byte && !err_now && !empty_end;

    always_comb begin
        st_d = st_q;
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        empty_line_d = empty_line_q;
        tx_go = 1'b0;
        tx_byte = CH_PROMPT;
        case (st_q)
            SPT_IDLE: begin
                if (load_start && port_ok) st_d = SPT_CLEAR;
                else if (save_start && port_ok) begin
                    rd_ptr_d = '0;
                    st_d = SPT_SEND;
                end
            end
            SPT_CLEAR: begin
                wr_ptr_d = '0;
                empty_line_d = 1'b1;
                st_d = SPT_PROMPT;
            end
            SPT_PROMPT: begin
                tx_go = 1'b1;
                if (tx_idle) st_d = SPT_RECV;
            end
            SPT_RECV: begin
                if (rx_ferr_q) st_d = SPT_IDLE;
                else if (rx_done_q) begin
                    if (line_end) begin
                        if (empty_line_q) st_d = SPT_DONE;
                        else st_d = SPT_PROCESS;
                        empty_line_d = 1'b1;
                    end else empty_line_d = 1'b0;
                    if (!empty_end) begin
                        if (mem_full) st_d = SPT_IDLE;
                        else wr_ptr_d = wr_ptr_q + 1'b1;
                    end
                end
            end
            SPT_PROCESS: begin
                if (line_processed) st_d = SPT_PROMPT;
            end
            SPT_SEND: begin
                if (save_end) st_d = SPT_EOP;
                else begin
                    tx_go = 1'b1;
                    tx_byte = mem_rd;
                    if (tx_idle) rd_ptr_d = rd_ptr_q + 1'b1;
                end
            end
            SPT_EOP: begin
                tx_go = 1'b1;
                tx_byte = CH_LF;
                if (tx_idle) st_d = SPT_DONE;
            end
            SPT_DONE: begin
                if (tx_idle) st_d = SPT_IDLE;
            end
            default: st_d = SPT_IDLE;
        endcase
    end

    // ****************************************
    // Program memory write
    // ****************************************
    // Bytes land in order; the linefeed of a line is kept
    always_ff @(posedge clk) begin
        if (store_now) mem[wr_ptr_q] <= rx_sh_q;
    end

    // ****************************************
    // Sequencer state
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q <= SPT_IDLE;
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            empty_line_q <= 1'b1;
        end else begin
            st_q <= st_d;
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            empty_line_q <= empty_line_d;
        end
    end

    // ****************************************
    // Status outputs
    // ****************************************
    // Next values of the registered outputs
    wire busy_d = (st_d != SPT_IDLE);
    wire ready_d = (st_q == SPT_DONE) && (st_d == SPT_IDLE);
    wire error_d = err_now || bad_start;
    wire cleared_d = (st_q == SPT_CLEAR);
    wire line_d = (st_q == SPT_RECV) && (st_d == SPT_PROCESS);

    // Busy falls with the ready or error pulse
    always_ff @(posedge clk) begin
        if (!rstn) begin
            busy <= 1'b0;
            ready_pulse <= 1'b0;
            sys_error <= 1'b0;
        end else begin
            busy <= busy_d;
            ready_pulse <= ready_d;
            sys_error <= error_d;
        end
    end

    // Cleared pulse comes two cycles after the load is taken
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mem_cleared <= 1'b0;
            mode_binary <= MODE_TEXT;
        end else begin
            mem_cleared <= cleared_d;
            // Mode is recorded only; the byte path is the same for both
            if (load_taken) mode_binary <= (load_mode == MODE_BINARY);
        end
    end

    // Last byte seen on the link, and the store and line pulses
    always_ff @(posedge clk) begin
        if (!rstn) begin
            line_valid <= 1'b0;
            rx_data <= 8'h00;
            rx_data_valid <= 1'b0;
        end else begin
            line_valid <= line_d;
            rx_data <= rx_sh_q;
            rx_data_valid <= store_now;
        end
    end
endmodule

// ===== verilog/spt_pkg.sv
// Constants and types for the serial program transfer block
package spt_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned BAUD = 19200;
    localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
    localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
    localparam int unsigned DATA_BITS = 8;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_PROMPT = 8'h3F;
    localparam logic [7:0] PORT_SERIAL = 8'h01;
    localparam logic MODE_TEXT = 1'b0;
    localparam logic MODE_BINARY = 1'b1;
    typedef enum logic [2:0] {
        SPT_IDLE,
        SPT_CLEAR,
        SPT_PROMPT,
        SPT_RECV,
        SPT_PROCESS,
        SPT_SEND,
        SPT_EOP,
        SPT_DONE
    } spt_state_type;
    typedef enum logic [1:0] {
        SPT_RX_IDLE,
        SPT_RX_START,
        SPT_RX_DATA,
        SPT_RX_STOP
    } spt_rx_type;
endpackage

// ===== verification/spt_checker.sv
// Port-level assertions for the serial program transfer block
`timescale 1ns/1ns
module spt_checker
    import spt_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic load_start,
    input wire logic save_start,
    input wire logic [7:0] port_num,
    input wire logic load_mode,
    input wire logic tx_pin,
    input wire logic busy,
    input wire logic ready_pulse,
    input wire logic sys_error,
    input wire logic mem_cleared,
    input wire logic mode_binary
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire go_ld = load_start && !busy && port_num == PORT_SERIAL;
    wire go_sv = save_start && !load_start && !busy && port_num == PORT_SERIAL;
    bad_port_a: assert property (load_start && !busy && port_num != PORT_SERIAL
        |-> ##[1:2] sys_error) else $error("bad port not refused");
    clear_first_a: assert property (go_ld |-> ##2 mem_cleared)
        else $error("memory not cleared");
    mode_rec_a: assert property (go_ld |-> ##3 mode_binary == $past(load_mode, 3))
        else $error("load mode not recorded");
    prompt_start_a: assert property (go_ld |-> ##3 !tx_pin)
        else $error("prompt frame late");
    save_begin_a: assert property (go_sv |=> busy ##[1:2] !tx_pin)
        else $error("save did not start");
    frame_start_a: assert property ($fell(tx_pin) |-> !tx_pin [*8])
        else $error("start bit too short");
    done_idle_a: assert property (ready_pulse || sys_error |=> !busy)
        else $error("busy after end");
    err_single_a: assert property (sys_error |=> !sys_error)
        else $error("error pulse too long");
    ready_single_a: assert property (ready_pulse |=> !ready_pulse)
        else $error("ready pulse too long");
endmodule
bind spt_top spt_checker i_spt_checker (.clk(clk), .rstn(rstn), .load_start(load_start),
    .save_start(save_start), .port_num(port_num), .load_mode(load_mode), .tx_pin(tx_pin),
    .busy(busy), .ready_pulse(ready_pulse), .sys_error(sys_error),
    .mem_cleared(mem_cleared), .mode_binary(mode_binary));

// ===== verification/spt_host.sv
// Host terminal model: 8-N-1 frames in both directions
`timescale 1ns/1ns
module spt_host
    import spt_pkg::*;
#(
    parameter int unsigned BIT_N = BIT_CYCLES
) (
    input wire logic clk,
    input wire logic tx_pin,
    output logic rx_pin
);
    logic [7:0] got;
    int rx_cnt = 0;
    initial rx_pin = 1'b1;
    always begin
        @(negedge tx_pin);
        repeat (BIT_N / 2) @(posedge clk);
        for (int i = 0; i < DATA_BITS; i++) begin
            repeat (BIT_N) @(posedge clk);
            got[i] = tx_pin;
        end
        repeat (BIT_N) @(posedge clk);
        if (tx_pin) rx_cnt++;
    end
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_pin <= f[i];
            repeat (BIT_N) @(posedge clk);
        end
        // One idle bit after each frame, also after a bad stop bit
        rx_pin <= 1'b1;
        repeat (BIT_N) @(posedge clk);
    endtask
endmodule

// ===== verification/spt_top_bench.sv
// Self-checking bench for the serial program transfer block
`timescale 1ns/1ns
module spt_top_bench;
    import spt_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, load_start = 1'b0, save_start = 1'b0, load_mode = 1'b0;
    logic [7:0] port_num = 8'h00, rx_data;
    logic rx_pin, tx_pin, busy, ready_pulse, sys_error, mem_cleared, mode_binary;
    logic line_proc = 1'b0;
    logic line_valid, rx_data_valid;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    // Clock figure given to the design so that a bit lasts 100 cycles
    localparam int unsigned SIM_HZ = 1_920_000;
    localparam int unsigned BIT_N = SIM_HZ / BAUD;
    always #5 clk = ~clk;
    spt_top #(.MEM_DEPTH(64), .CLK_FREQ_HZ(SIM_HZ)) i_spt_top (.clk(clk), .rstn(rstn),
        .load_start(load_start), .save_start(save_start), .port_num(port_num),
        .load_mode(load_mode), .line_processed(line_proc), .rx_pin(rx_pin), .tx_pin(tx_pin),
        .busy(busy), .ready_pulse(ready_pulse), .sys_error(sys_error),
        .mem_cleared(mem_cleared), .mode_binary(mode_binary), .line_valid(line_valid),
        .rx_data(rx_data), .rx_data_valid(rx_data_valid));
    spt_host #(.BIT_N(BIT_N)) i_spt_host (.clk(clk), .tx_pin(tx_pin), .rx_pin(rx_pin));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic await(ref logic s, input int lim, input string name);
        int n;
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
        chk(name, 8'h01, {7'h00, s});
    endtask
    task automatic await_byte(input logic [7:0] exp);
        int n;
        int base;
        n = 0;
        base = i_spt_host.rx_cnt;
        while (i_spt_host.rx_cnt <= base && n < 12 * BIT_N) begin
            @(posedge clk);
            n++;
        end
        chk("tx_frame", 8'h01, {7'h00, i_spt_host.rx_cnt > base});
        chk("tx_byte", exp, i_spt_host.got);
    endtask
    task automatic start(input logic ld, input logic [7:0] port, input logic mode);
        @(posedge clk);
        #1 load_start = ld;
        save_start = !ld;
        port_num = port;
        load_mode = mode;
        @(posedge clk);
        #1 load_start = 1'b0;
        save_start = 1'b0;
    endtask
    task automatic t_bad_port();
        start(1'b1, 8'h02, 1'b0);
        await(sys_error, 4, "sys_error");
        chk("busy", 8'h00, {7'h00, busy});
    endtask
    task automatic t_load_abort();
        start(1'b1, PORT_SERIAL, MODE_BINARY);
        await(mem_cleared, 4, "mem_cleared");
        chk("mode_binary", 8'h01, {7'h00, mode_binary});
        await_byte(CH_PROMPT);
        @(posedge clk);
        fork
            i_spt_host.send(8'h41, 1'b0);
            await(sys_error, 11 * BIT_N, "sys_error");
        join
        chk("busy", 8'h00, {7'h00, busy});
    endtask
    task automatic t_save();
        start(1'b0, PORT_SERIAL, MODE_TEXT);
        fork
            await_byte(CH_LF);
            await(ready_pulse, 13 * BIT_N, "ready_pulse");
        join
    endtask
    task automatic t_load_lines();
        start(1'b1, PORT_SERIAL, MODE_TEXT);
        await(mem_cleared, 4, "mem_cleared");
        chk("mode_binary", 8'h00, {7'h00, mode_binary});
        await_byte(CH_PROMPT);
        @(posedge clk);
        fork
            i_spt_host.send(8'h58, 1'b1);
            await(rx_data_valid, 11 * BIT_N, "rx_data_valid");
        join
        chk("rx_data", 8'h58, rx_data);
        fork
            i_spt_host.send(CH_LF, 1'b1);
            await(line_valid, 11 * BIT_N, "line_valid");
        join
        chk("rx_data", CH_LF, rx_data);
        chk("busy", 8'h01, {7'h00, busy});
        fork
            await_byte(CH_PROMPT);
            begin
                repeat (20) @(posedge clk);
                chk("tx_pin", 8'h01, {7'h00, tx_pin});
                #1 line_proc = 1'b1;
                @(posedge clk);
                #1 line_proc = 1'b0;
            end
        join
        @(posedge clk);
        fork
            i_spt_host.send(CH_LF, 1'b1);
            await(ready_pulse, 11 * BIT_N, "ready_pulse");
        join
        chk("busy", 8'h00, {7'h00, busy});
    endtask
    task automatic t_save_lines();
        start(1'b0, PORT_SERIAL, MODE_TEXT);
        await_byte(8'h58);
        await_byte(CH_LF);
        await_byte(CH_LF);
        await(ready_pulse, 3 * BIT_N, "ready_pulse");
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        t_bad_port();
        t_load_abort();
        t_save();
        t_load_lines();
        t_save_lines();
        tally_and_finish();
    end
endmodule
